// ---- core/pi_pkg.sv ----
// constants, register map and types for the pi speed controller
package pi_pkg;
   // -----------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // -----------------------------------------------------------------
   localparam logic [5:0] OFF_GAIN      = 6'h00;
   localparam logic [5:0] OFF_ITIME     = 6'h04;
   localparam logic [5:0] OFF_MODE      = 6'h08;
   localparam logic [5:0] OFF_SP_SRC    = 6'h0C;
   localparam logic [5:0] OFF_SP_DIG    = 6'h10;
   localparam logic [5:0] OFF_FB_SRC    = 6'h14;
   localparam logic [5:0] OFF_STBY_TIME = 6'h18;
   localparam logic [5:0] OFF_WAKE_LVL  = 6'h1C;
   localparam logic [5:0] OFF_STATUS    = 6'h20;
   localparam logic [5:0] OFF_OUTPUT    = 6'h24;
   localparam logic [5:0] OFF_CTRL_MODE = 6'h28;
   // -----------------------------------------------------------------
   // reset values and limits, tenths of a unit except the mode, source and control-mode codes
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_GAIN      = 16'h000A;
   localparam logic [15:0] RST_ITIME     = 16'h000A;
   localparam logic [15:0] RST_SP_DIG    = 16'h0000;
   localparam logic [15:0] RST_STBY_TIME = 16'h0000;
   localparam logic [15:0] RST_WAKE_LVL  = 16'h0032;
   localparam logic [15:0] RST_CTRL_MODE = 16'h0000;
   localparam logic [15:0] MAX_GAIN      = 16'h012C;
   localparam logic [15:0] MAX_ITIME     = 16'h012C;
   localparam logic [15:0] MAX_PCT       = 16'h03E8;
   localparam logic [15:0] MAX_STBY      = 16'h00FA;
   localparam logic [15:0] MAX_MODE      = 16'h0003;
   localparam logic [15:0] MAX_SP_SRC    = 16'h0001;
   localparam logic [15:0] MAX_FB_SRC    = 16'h0005;
   localparam logic [15:0] CTRL_PI_A     = 16'h0005;
   localparam logic [15:0] CTRL_PI_B     = 16'h0006;
   localparam logic [15:0] DC_FULL_SCALE = 16'h03E8;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ          = 100_000_000;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int DIV_CYCLES      = 32;
   localparam logic [3:0] DIV_LAST = 4'(DIV_CYCLES / 2 - 1);
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN    = 2'b00,
      ST_STBY   = 2'b01,
      ST_WAKE   = 2'b10
   } run_state_t;
endpackage : pi_pkg

// ---- core/pi_div_if.sv ----
// request and answer bundle between the controller and its divider
`timescale 1ns/100ps
interface pi_div_if;
   logic        start;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic        done;
   logic [31:0] quotient;
   modport master (output start, output dividend, output divisor,
                   input done, input quotient);
   modport slave  (input start, input dividend, input divisor,
                   output done, output quotient);
endinterface : pi_div_if

// ---- core/pi_divider.sv ----
// sequential unsigned divider, two quotient bits per cycle
`timescale 1ns/100ps
module pi_divider
   import pi_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   pi_div_if.slave   div
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [31:0] q_reg,   q_next;
   logic [16:0] r_reg,   r_next;
   logic [15:0] d_reg,   d_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic        busy_reg, busy_next;
   logic        done_reg, done_next;
   logic [16:0] r1;
   logic [31:0] q1;

   always_comb begin
      q_next    = q_reg;
      r_next    = r_reg;
      d_next    = d_reg;
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      r1        = r_reg;
      q1        = q_reg;
      if (div.start && !busy_reg) begin
         q_next    = div.dividend;
         r_next    = 17'h00000;
         d_next    = (div.divisor == 16'h0000) ? 16'h0001 : div.divisor;
         cnt_next  = 4'h0;
         busy_next = 1'b1;
      end else if (busy_reg) begin
         // two restoring steps per cycle keeps the loop short
         r1 = {r_reg[15:0], q_reg[31]};
         q1 = {q_reg[30:0], 1'b0};
         if (r1 >= {1'b0, d_reg}) begin
            r1    = r1 - {1'b0, d_reg};
            q1[0] = 1'b1;
         end
         r_next = {r1[15:0], q1[31]};
         q_next = {q1[30:0], 1'b0};
         if (r_next >= {1'b0, d_reg}) begin
            r_next    = r_next - {1'b0, d_reg};
            q_next[0] = 1'b1;
         end
         cnt_next = cnt_reg + 4'h1;
         if (cnt_reg == DIV_LAST) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q_reg    <= 32'h00000000;
         r_reg    <= 17'h00000;
         d_reg    <= 16'h0001;
         cnt_reg  <= 4'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         q_reg    <= q_next;
         r_reg    <= r_next;
         d_reg    <= d_next;
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign div.done     = done_reg;
   assign div.quotient = q_reg;
endmodule : pi_divider

// ---- core/pi_speed_controller_standby.sv ----
// pi process controller with standby timer and wake on error
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module pi_speed_controller_standby
   import pi_pkg::*;
#(
   parameter int TICK = TICK_CYCLES
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic [5:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic [15:0] i_analog_in1_level,
   input  wire logic [15:0] i_analog_in2_level,
   input  wire logic [15:0] i_motor_current,
   input  wire logic [15:0] i_motor_rated_current,
   input  wire logic [15:0] i_dc_bus_volts,
   input  wire logic        i_at_min_speed,
   output logic      [15:0] o_pi_output,
   output logic             o_motor_enable,
   output logic             o_standby
);
   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [15:0] gain_reg,  gain_next;
   logic [15:0] itime_reg, itime_next;
   logic [1:0]  mode_reg,  mode_next;
   logic        spsrc_reg, spsrc_next;
   logic [15:0] spdig_reg, spdig_next;
   logic [2:0]  fbsrc_reg, fbsrc_next;
   logic [15:0] stby_reg,  stby_next;
   logic [15:0] wake_reg,  wake_next;
   logic [15:0] ctrl_reg,  ctrl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        ack_reg,   ack_next;
   logic [15:0] wd;
   logic        wr_go;

   assign wd    = i_avs_writedata[15:0];
   assign wr_go = i_avs_write && !ack_reg;

   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
      lim = (v > m) ? m : v;
   endfunction : lim

   always_comb begin
      gain_next  = gain_reg;
      itime_next = itime_reg;
      mode_next  = mode_reg;
      spsrc_next = spsrc_reg;
      spdig_next = spdig_reg;
      fbsrc_next = fbsrc_reg;
      stby_next  = stby_reg;
      wake_next  = wake_reg;
      ctrl_next  = ctrl_reg;
      rdata_next = rdata_reg;
      ack_next   = 1'b0;
      // one wait cycle: the answer comes at the second edge of a request
      if ((i_avs_read || i_avs_write) && !ack_reg) begin
         ack_next = 1'b1;
      end
      if (wr_go) begin
         // out of range writes saturate to the limit
         unique case (i_avs_address)
            OFF_GAIN:      gain_next  = lim(wd, MAX_GAIN);
            OFF_ITIME:     itime_next = lim(wd, MAX_ITIME);
            OFF_MODE:      mode_next  = 2'(lim(wd, MAX_MODE));
            OFF_SP_SRC:    spsrc_next = 1'(lim(wd, MAX_SP_SRC));
            OFF_SP_DIG:    spdig_next = lim(wd, MAX_PCT);
            OFF_FB_SRC:    fbsrc_next = 3'(lim(wd, MAX_FB_SRC));
            OFF_STBY_TIME: stby_next  = lim(wd, MAX_STBY);
            OFF_WAKE_LVL:  wake_next  = lim(wd, MAX_PCT);
            OFF_CTRL_MODE: ctrl_next  = wd;
            default:       ;
         endcase
      end
      if (i_avs_read && !ack_reg) begin
         unique case (i_avs_address)
            OFF_GAIN:      rdata_next = {16'h0000, gain_reg};
            OFF_ITIME:     rdata_next = {16'h0000, itime_reg};
            OFF_MODE:      rdata_next = {30'h00000000, mode_reg};
            OFF_SP_SRC:    rdata_next = {31'h00000000, spsrc_reg};
            OFF_SP_DIG:    rdata_next = {16'h0000, spdig_reg};
            OFF_FB_SRC:    rdata_next = {29'h00000000, fbsrc_reg};
            OFF_STBY_TIME: rdata_next = {16'h0000, stby_reg};
            OFF_WAKE_LVL:  rdata_next = {16'h0000, wake_reg};
            OFF_STATUS:    rdata_next = {30'h00000000, o_motor_enable, o_standby};
            OFF_OUTPUT:    rdata_next = {16'h0000, o_pi_output};
            OFF_CTRL_MODE: rdata_next = {16'h0000, ctrl_reg};
            default:       rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gain_reg  <= RST_GAIN;
         itime_reg <= RST_ITIME;
         mode_reg  <= 2'h0;
         spsrc_reg <= 1'b0;
         spdig_reg <= RST_SP_DIG;
         fbsrc_reg <= 3'h0;
         stby_reg  <= RST_STBY_TIME;
         wake_reg  <= RST_WAKE_LVL;
         ctrl_reg  <= RST_CTRL_MODE;
         rdata_reg <= 32'h00000000;
         ack_reg   <= 1'b0;
      end else begin
         gain_reg  <= gain_next;
         itime_reg <= itime_next;
         mode_reg  <= mode_next;
         spsrc_reg <= spsrc_next;
         spdig_reg <= spdig_next;
         fbsrc_reg <= fbsrc_next;
         stby_reg  <= stby_next;
         wake_reg  <= wake_next;
         ctrl_reg  <= ctrl_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
      end
   end

   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
   assign o_avs_readdata    = rdata_reg;

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   logic [15:0] s1 [5];
   logic [15:0] s2 [5];
   logic [15:0] raw [5];
   logic        mins1, mins2;
   assign raw[0] = i_analog_in1_level;
   assign raw[1] = i_analog_in2_level;
   assign raw[2] = i_motor_current;
   assign raw[3] = i_motor_rated_current;
   assign raw[4] = i_dc_bus_volts;

   // multi-bit pins are assumed quasi static between controller ticks
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               s1[g] <= 16'h0000;
               s2[g] <= 16'h0000;
            end else begin
               s1[g] <= raw[g];
               s2[g] <= s1[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mins1 <= 1'b0;
         mins2 <= 1'b0;
      end else begin
         mins1 <= i_at_min_speed;
         mins2 <= mins1;
      end
   end

   // -----------------------------------------------------------------
   // setpoint, feedback and error
   // -----------------------------------------------------------------
   logic [15:0] a1, a2, setpoint, feedback, cur_pct;
   logic [31:0] dcv;
   logic signed [17:0] err;
   logic [17:0] err_mag;
   logic        inverse;
   assign a1       = lim(s2[0], MAX_PCT);
   assign a2       = lim(s2[1], MAX_PCT);
   assign setpoint = spsrc_reg ? a1 : spdig_reg;
   assign dcv      = 32'(s2[4]) * 32'(MAX_PCT) / 32'(DC_FULL_SCALE);
   assign inverse  = mode_reg[0];

   always_comb begin
      unique case (fbsrc_reg)
         3'h0:    feedback = a2;
         3'h1:    feedback = a1;
         3'h2:    feedback = cur_pct;
         3'h3:    feedback = lim(dcv[15:0], MAX_PCT);
         3'h4:    feedback = (a1 > a2) ? a1 - a2 : 16'h0000;
         3'h5:    feedback = (a1 > a2) ? a1 : a2;
         default: feedback = a2;
      endcase
   end

   // direct: error = sp - fb, inverse: fb - sp
   assign err = inverse ? 18'(signed'({2'b00, feedback}) - signed'({2'b00, setpoint}))
                        : 18'(signed'({2'b00, setpoint}) - signed'({2'b00, feedback}));
   assign err_mag = err[17] ? 18'(-err) : 18'(err);

   // -----------------------------------------------------------------
   // pi step: current percent and integral increment via divider
   // -----------------------------------------------------------------
   pi_div_if div ();
   pi_divider u_div (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .div     (div)
   );

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CUR  = 2'b01,
      PH_INT  = 2'b10
   } phase_t;

   phase_t            ph_reg, ph_next;
   logic [31:0]       tick_reg, tick_next;
   logic [15:0]       cur_reg, cur_next;
   logic signed [31:0] integ_reg, integ_next;
   logic [15:0]       out_reg, out_next;
   logic [15:0]       stcnt_reg, stcnt_next;
   run_state_t        st_reg, st_next;
   logic signed [31:0] prop, incr, sum, acc;
   logic              tick, pi_ctrl;

   assign cur_pct = cur_reg;
   assign tick    = (tick_reg == 32'(TICK - 1));
   assign pi_ctrl = (ctrl_reg == CTRL_PI_A) || (ctrl_reg == CTRL_PI_B);
   // gain in tenths: err * gain / 10
   assign prop    = 32'(err) * signed'(32'(gain_reg)) / 32'sd10;
   // increment per tick of 0.1 s, scaled in thousandths of percent
   assign incr    = (itime_reg == 16'h0000) ? 32'sd0 :
                    (err[17] ? -signed'(div.quotient) : signed'(div.quotient));

   always_comb begin
      div.start    = 1'b0;
      div.dividend = 32'h00000000;
      div.divisor  = 16'h0001;
      ph_next      = ph_reg;
      tick_next    = tick ? 32'h00000000 : tick_reg + 32'h00000001;
      cur_next     = cur_reg;
      integ_next   = integ_reg;
      out_next     = out_reg;
      stcnt_next   = stcnt_reg;
      st_next      = st_reg;
      acc          = integ_reg;
      sum          = 32'sd0;
      unique case (ph_reg)
         PH_IDLE: begin
            if (tick) begin
               div.start    = 1'b1;
               div.dividend = 32'(s2[2]) * 32'(MAX_PCT);
               div.divisor  = s2[3];
               ph_next      = PH_CUR;
            end
         end
         PH_CUR: begin
            if (div.done) begin
               // saturate the full quotient, a bare slice would wrap first
               cur_next     = (div.quotient > 32'(MAX_PCT)) ? MAX_PCT : div.quotient[15:0];
               div.start    = 1'b1;
               div.dividend = 32'(err_mag) * 32'(gain_reg) * 32'd10;
               div.divisor  = itime_reg;
               ph_next      = PH_INT;
            end
         end
         PH_INT: begin
            if (div.done) begin
               ph_next = PH_IDLE;
               if (st_reg == ST_RUN) begin
                  acc = integ_reg + incr;
                  if (acc < 32'sd0) acc = 32'sd0;
                  if (acc > 32'(MAX_PCT) * 32'sd100) acc = 32'(MAX_PCT) * 32'sd100;
                  integ_next = acc;
                  sum = prop + acc / 32'sd100;
                  out_next = (sum < 32'sd0) ? 16'h0000 :
                             (sum > 32'(MAX_PCT)) ? MAX_PCT : sum[15:0];
               end
               // -----------------------------------------------------
               // standby sequencing at tick rate
               // -----------------------------------------------------
               unique case (st_reg)
                  ST_RUN: begin
                     if (stby_reg != 16'h0000 && mins2) begin
                        if (stcnt_reg + 16'h0001 >= stby_reg) begin
                           st_next    = ST_STBY;
                           stcnt_next = 16'h0000;
                        end else begin
                           stcnt_next = stcnt_reg + 16'h0001;
                        end
                     end else begin
                        stcnt_next = 16'h0000;
                     end
                  end
                  ST_STBY: begin
                     // outside pi control a standby drive waits for speed demand
                     if ((pi_ctrl && !err[17] && err_mag >= 18'(wake_reg)) ||
                         (!pi_ctrl && !mins2)) begin
                        st_next = ST_WAKE;
                     end
                  end
                  ST_WAKE: begin
                     if (mode_reg[1]) begin
                        out_next   = MAX_PCT;
                        integ_next = 32'(MAX_PCT) * 32'sd100;
                     end
                     st_next = ST_RUN;
                  end
                  default: st_next = ST_RUN;
               endcase
            end
         end
         default: ph_next = PH_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ph_reg    <= PH_IDLE;
         tick_reg  <= 32'h00000000;
         cur_reg   <= 16'h0000;
         integ_reg <= 32'sd0;
         out_reg   <= 16'h0000;
         stcnt_reg <= 16'h0000;
         st_reg    <= ST_RUN;
      end else begin
         ph_reg    <= ph_next;
         tick_reg  <= tick_next;
         cur_reg   <= cur_next;
         integ_reg <= integ_next;
         out_reg   <= out_next;
         stcnt_reg <= stcnt_next;
         st_reg    <= st_next;
      end
   end

   assign o_pi_output    = out_reg;
   assign o_standby      = (st_reg == ST_STBY);
   assign o_motor_enable = (st_reg != ST_STBY);
endmodule : pi_speed_controller_standby

// ---- sim/pi_speed_controller_standby_sva.sv ----
// port checker for the pi speed controller
`timescale 1ns/100ps
module pi_speed_controller_standby_chk
   import pi_pkg::*;
#(
   parameter int TICK = 100
)(
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_at_min_speed,
   input wire logic [15:0] o_pi_output,
   input wire logic        o_motor_enable,
   input wire logic        o_standby
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // -----------------------------------------------------------------
   // helper: cycles since the output last moved
   // -----------------------------------------------------------------
   logic [15:0] out_reg, out_next;
   int          since_reg, since_next;
   always_comb begin
      out_next   = o_pi_output;
      since_next = (o_pi_output != out_reg) ? 0 : ((since_reg < TICK) ? since_reg + 1 : since_reg);
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_reg   <= '0;
         since_reg <= 0;
      end else begin
         out_reg   <= out_next;
         since_reg <= since_next;
      end
   end
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("waitrequest held past one cycle");
   AST_IDLE_FREE: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest without request");
   AST_RDATA_HOLD: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("read data moved without read");
   AST_OUT_RANGE: assert property (o_pi_output <= MAX_PCT)
      else $error("pi output above full scale");
   AST_STBY_OFF: assert property (o_standby |-> !o_motor_enable)
      else $error("motor enabled in standby");
   AST_STBY_MIN: assert property ($rose(o_standby) |-> $past(i_at_min_speed, 3))
      else $error("standby without minimum speed");
   AST_STBY_HOLD: assert property ($rose(o_standby) |=> o_standby[*8])
      else $error("standby left before a tick");
   AST_OUT_PACED: assert property ((o_pi_output != out_reg) |-> since_reg >= TICK - 1)
      else $error("pi output moved between ticks");
endmodule : pi_speed_controller_standby_chk

bind pi_speed_controller_standby pi_speed_controller_standby_chk #(.TICK(TICK)) chk_i (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_at_min_speed(i_at_min_speed), .o_pi_output(o_pi_output),
   .o_motor_enable(o_motor_enable), .o_standby(o_standby));

// ---- sim/pi_plant_model.sv ----
// sensor and motor core model feeding the controller
`timescale 1ns/100ps
module pi_plant_model (
   input  wire logic        i_clk,
   output logic      [15:0] o_an1,
   output logic      [15:0] o_an2,
   output logic      [15:0] o_cur,
   output logic      [15:0] o_rated,
   output logic      [15:0] o_dc,
   output logic             o_at_min
);
   // rated current fixed so each current unit maps to half a percent of feedback
   initial begin
      o_an1    = '0;
      o_an2    = '0;
      o_cur    = '0;
      o_rated  = 16'h00C8;
      o_dc     = '0;
      o_at_min = 1'b0;
   end
   // new readings land just after an edge, like a sampled front end
   task automatic apply(input logic [15:0] a1, a2, cur, dc, input logic at_min);
      @(posedge i_clk);
      o_an1    <= a1;
      o_an2    <= a2;
      o_cur    <= cur;
      o_dc     <= dc;
      o_at_min <= at_min;
   endtask : apply
endmodule : pi_plant_model

// ---- sim/tb_top.sv ----
// self-checking bench for the pi speed controller
`timescale 1ns/100ps
module tb_top;
   import pi_pkg::*;
   localparam int TICK = 100;
   localparam logic [5:0]  OFFS [8] = '{OFF_GAIN, OFF_ITIME, OFF_MODE, OFF_SP_SRC, OFF_SP_DIG,
                                        OFF_FB_SRC, OFF_STBY_TIME, OFF_WAKE_LVL};
   localparam logic [15:0] RSTV [8] = '{RST_GAIN, RST_ITIME, 16'h0, 16'h0, RST_SP_DIG, 16'h0,
                                        RST_STBY_TIME, RST_WAKE_LVL};
   localparam logic [15:0] MAXV [8] = '{MAX_GAIN, MAX_ITIME, MAX_MODE, MAX_SP_SRC, MAX_PCT,
                                        MAX_FB_SRC, MAX_STBY, MAX_PCT};
   localparam logic [15:0] USEV [8] = '{16'h000A, 16'h0, 16'h0, 16'h0, 16'h01F4, 16'h0,
                                        16'h0, 16'h0032};
   localparam logic [15:0] FBEXP [6] = '{16'h0190, 16'h00C8, 16'h00C8, 16'h012C, 16'h012C,
                                         16'h00C8};
   logic i_clk = 1'b0, i_rst_b = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
   logic [5:0]  addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        wait_req, at_min, motor_en, stby;
   logic [15:0] an1, an2, cur, rated, dc, pi_out;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   always #5 i_clk = ~i_clk;
   pi_plant_model plant_i (.i_clk(i_clk), .o_an1(an1), .o_an2(an2), .o_cur(cur),
      .o_rated(rated), .o_dc(dc), .o_at_min(at_min));
   pi_speed_controller_standby #(.TICK(TICK)) pi_speed_controller_standby_i (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(addr), .i_avs_read(rd_en),
      .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req), .i_analog_in1_level(an1), .i_analog_in2_level(an2),
      .i_motor_current(cur), .i_motor_rated_current(rated), .i_dc_bus_volts(dc),
      .i_at_min_speed(at_min), .o_pi_output(pi_out), .o_motor_enable(motor_en),
      .o_standby(stby));
   // -----------------------------------------------------------------
   // bus and check tasks
   // -----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge i_clk);
      addr  <= a;
      wdata <= d;
      if (wr) wr_en <= 1'b1; else rd_en <= 1'b1;
      do @(posedge i_clk); while (wait_req !== 1'b0);
      q = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask : bus
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, '0, q);
      chk("register read", exp, q);
   endtask : rchk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, {16'h0, d}, q);
   endtask : wr
   // analog inputs pass a synchroniser, so give a few ticks to settle
   task automatic settle();
      repeat (3 * TICK) @(posedge i_clk);
   endtask : settle
   task automatic out_chk(input logic [15:0] exp);
      settle();
      chk("pi output", {16'h0, exp}, {16'h0, pi_out});
   endtask : out_chk
   task automatic wait_stby(input logic v);
      for (int n = 0; n < 20 * TICK && stby !== v; n++) @(posedge i_clk);
   endtask : wait_stby
   task automatic report_and_stop();
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // -----------------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         rchk(OFFS[k], {16'h0, RSTV[k]});
         wr(OFFS[k], 16'hFFFF);
         rchk(OFFS[k], {16'h0, MAXV[k]});
         wr(OFFS[k], USEV[k]);
      end
      wr(OFF_STATUS, 16'h0);
      rchk(OFF_STATUS, 32'h2);
      rchk(6'h2C, 32'h0);
      plant_i.apply(16'd300, 16'd100, 16'd60, 16'd200, 1'b0);
      for (int k = 0; k < 6; k++) begin
         wr(OFF_FB_SRC, 16'(k));
         out_chk(FBEXP[k]);
      end
      rchk(OFF_OUTPUT, 32'h00C8);
      plant_i.apply(16'd100, 16'd300, 16'd60, 16'd200, 1'b0);
      wr(OFF_FB_SRC, 16'd4);
      out_chk(16'd500);
      wr(OFF_FB_SRC, 16'd5);
      out_chk(16'd200);
      wr(OFF_FB_SRC, 16'd0);
      wr(OFF_MODE, 16'd1);
      out_chk(16'd0);
      plant_i.apply(16'd300, 16'd700, 16'd0, 16'd0, 1'b0);
      out_chk(16'd200);
      wr(OFF_MODE, 16'd0);
      out_chk(16'd0);
      plant_i.apply(16'd300, 16'd100, 16'd0, 16'd0, 1'b0);
      wr(OFF_SP_SRC, 16'd1);
      out_chk(16'd200);
      wr(OFF_GAIN, 16'd20);
      out_chk(16'd400);
      wr(OFF_GAIN, 16'd10);
      wr(OFF_SP_SRC, 16'd0);
      wr(OFF_CTRL_MODE, CTRL_PI_A);
      wr(OFF_STBY_TIME, 16'd3);
      for (int m = 2; m < 4; m++) begin
         wr(OFF_MODE, 16'(m));
         plant_i.apply(16'd0, 16'd500, 16'd0, 16'd0, 1'b1);
         wait_stby(1'b1);
         chk("standby", 32'h0, {31'h0, motor_en});
         rchk(OFF_STATUS, 32'h1);
         plant_i.apply(16'd0, (m == 2) ? 16'd480 : 16'd520, 16'd0, 16'd0, 1'b1);
         settle();
         chk("standby", 32'h1, {31'h0, stby});
         plant_i.apply(16'd0, (m == 2) ? 16'd400 : 16'd600, 16'd0, 16'd0, 1'b0);
         wait_stby(1'b0);
         // the forced output lands one tick after leaving standby
         repeat (TICK + 5) @(posedge i_clk);
         chk("wake output", 32'h03E8, {16'h0, pi_out});
         // in mode 2 drain the integral so the output falls to zero; in mode 3 the inverse error keeps it full
         wr(OFF_ITIME, 16'd1);
         plant_i.apply(16'd0, 16'd1000, 16'd0, 16'd0, 1'b0);
         out_chk((m == 2) ? 16'd0 : 16'd1000);
         wr(OFF_ITIME, 16'd0);
      end
      report_and_stop();
   end
endmodule : tb_top
